// *** pkg/tsc_pkg.sv ***
// Package: constants and carriers for the terminal speed command logic
package tsc_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned NUM_TERM = 8;
   localparam int unsigned FREQ_W = 16;
   localparam int unsigned FUNC_W = 5;
   // Frequencies in units of 0.01 Hz
   localparam logic [15:0] FREQ_MAX_SETTING = 16'h9C40;
   localparam logic [15:0] JOG_SPEED_DEFAULT = 16'h03E8;
   localparam logic [15:0] STEP_SIZE_DEFAULT = 16'h0000;
   localparam logic [7:0] START_DC_LEVEL_MAX = 8'hC8;
   localparam logic [7:0] START_DC_LEVEL_DEFAULT = 8'h32;
   localparam logic [3:0] FREQ_SRC_UPDOWN = 4'h8;
   localparam logic [1:0] UPDOWN_MODE_CONT = 2'h0;
   localparam logic [1:0] UPDOWN_MODE_STEP = 2'h1;
   localparam logic [1:0] UPDOWN_MODE_COMBO = 2'h2;
   // Terminal function codes
   localparam logic [4:0] FN_JOG = 5'h04;
   localparam logic [4:0] FN_DC_BRAKE_STOP = 5'h0B;
   localparam logic [4:0] FN_RAISE = 5'h0F;
   localparam logic [4:0] FN_LOWER = 5'h10;
   localparam logic [4:0] FN_THREE_WIRE = 5'h11;
   localparam logic [4:0] FN_SAVED_CLEAR = 5'h19;
   localparam logic [4:0] FN_JOG_FWD = 5'h1A;
   localparam logic [4:0] FN_JOG_REV = 5'h1B;
   // Times
   localparam int unsigned HOLD_TIME_MS = 3000;
   localparam int unsigned DEBOUNCE_TIME_US = 1000;
   localparam int unsigned TICK_TIME_US = 1000;
   localparam int unsigned HOLD_CYCLES = HOLD_TIME_MS * 1000 * CLK_MHZ;
   localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * CLK_MHZ;
   localparam int unsigned TICK_CYCLES = TICK_TIME_US * CLK_MHZ;
   localparam int unsigned TICK_W = 32;

   typedef struct packed {
      logic [15:0] jog_speed;
      logic [15:0] max_speed_limit;
      logic [15:0] min_start_speed;
      logic [15:0] high_limit;
      logic [15:0] low_limit;
      logic [15:0] updown_step_size;
      logic [15:0] ramp_rate;
   } tsc_speed_cfg_s;

   typedef struct packed {
      logic [7:0] start_dc_level;
      logic [15:0] start_dc_duration;
      logic [15:0] dwell_speed;
      logic [15:0] dwell_time;
   } tsc_brake_cfg_s;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DWELL,
      ST_START_DC,
      ST_RUN,
      ST_STOP_DC
   } tsc_state_e;
endpackage : tsc_pkg

// *** design/tsc_debounce.sv ***
// Debouncer: two-flop synchroniser followed by a stability filter
`timescale 1ns/1ps
`default_nettype none
module tsc_debounce #(
   parameter int unsigned CYCLES = 250000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Raw terminal and filtered level
   input wire logic raw,
   output logic clean
);
   logic sync1;
   logic sync2;
   logic [31:0] count;
   logic [31:0] next_count;
   logic next_clean;

   always_comb
   begin
      next_count = 32'h0;
      next_clean = clean;
      if (sync2 != clean)
      begin
         if (count >= CYCLES - 1)
            next_clean = sync2;
         else
            next_count = count + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         count <= 32'h0;
         clean <= 1'b0;
      end
      else
      begin
         sync1 <= raw;
         sync2 <= sync1;
         count <= next_count;
         clean <= next_clean;
      end
   end
endmodule : tsc_debounce
`default_nettype wire

// *** design/tsc_core.sv ***
// Terminal speed command logic: braking, jog, up-down and three-wire run
`timescale 1ns/1ps
`default_nettype none
module tsc_core #(
   parameter int unsigned HOLD_CYCLES = tsc_pkg::HOLD_CYCLES,
   parameter int unsigned DEBOUNCE_CYCLES = tsc_pkg::DEBOUNCE_CYCLES,
   parameter int unsigned TICK_CYCLES = tsc_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Terminals and their function codes
   input wire logic [7:0] input_terminal,
   input wire logic [39:0] terminal_function,
   // Run commands
   input wire logic forward_run_cmd,
   input wire logic reverse_run_cmd,
   // Settings
   input wire logic [3:0] freq_source,
   input wire logic [15:0] keypad_reference,
   input wire tsc_pkg::tsc_speed_cfg_s speed_cfg,
   input wire tsc_pkg::tsc_brake_cfg_s brake_cfg,
   input wire logic [1:0] updown_mode_select,
   input wire logic updown_save_enable,
   // Drive outputs
   output logic [15:0] speed_target,
   output logic [15:0] output_speed,
   output logic reverse_dir,
   output logic dc_inject,
   output logic [7:0] dc_level,
   output logic running,
   // Saved reference
   output logic [15:0] updown_saved_reference
);
   logic [7:0] term;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_db
         tsc_debounce #(
            .CYCLES(DEBOUNCE_CYCLES)
         ) u_db (
            .clk(clk),
            .nrst(nrst),
            .raw(input_terminal[gi]),
            .clean(term[gi])
         );
      end
   endgenerate

   // OR of terminals assigned a given function code
   function automatic logic fn_active(input logic [7:0] t,
                                      input logic [39:0] f,
                                      input logic [4:0] code);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 8; i++)
         if (f[i*5 +: 5] == code && t[i])
            r = 1'b1;
      return r;
   endfunction : fn_active

   function automatic logic fn_assigned(input logic [39:0] f,
                                        input logic [4:0] code);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 8; i++)
         if (f[i*5 +: 5] == code)
            r = 1'b1;
      return r;
   endfunction : fn_assigned

   // Decoded commands
   logic jog;
   logic jog_fwd;
   logic jog_rev;
   logic dc_stop_cmd;
   logic raise;
   logic lower;
   logic clr;
   logic three_hold;
   logic three_wire;
   logic updown_sel;
   logic ud_assigned;
   always_comb
   begin
      jog = fn_active(term, terminal_function, tsc_pkg::FN_JOG);
      jog_fwd = fn_active(term, terminal_function, tsc_pkg::FN_JOG_FWD);
      jog_rev = fn_active(term, terminal_function, tsc_pkg::FN_JOG_REV);
      dc_stop_cmd = fn_active(term, terminal_function,
                              tsc_pkg::FN_DC_BRAKE_STOP);
      raise = fn_active(term, terminal_function, tsc_pkg::FN_RAISE);
      lower = fn_active(term, terminal_function, tsc_pkg::FN_LOWER);
      clr = fn_active(term, terminal_function, tsc_pkg::FN_SAVED_CLEAR);
      three_hold = fn_active(term, terminal_function,
                             tsc_pkg::FN_THREE_WIRE);
      three_wire = fn_assigned(terminal_function, tsc_pkg::FN_THREE_WIRE);
      ud_assigned = fn_assigned(terminal_function, tsc_pkg::FN_RAISE) ||
                    fn_assigned(terminal_function, tsc_pkg::FN_LOWER);
      updown_sel = (freq_source == tsc_pkg::FREQ_SRC_UPDOWN);
   end

   // Three-wire run latch
   logic run_fwd_latch;
   logic run_rev_latch;
   logic next_run_fwd_latch;
   logic next_run_rev_latch;
   logic run_fwd;
   logic run_rev;
   always_comb
   begin
      next_run_fwd_latch = 1'b0;
      next_run_rev_latch = 1'b0;
      // latch momentary pulses; run commands are not debounced, a one-cycle pulse latches
      if (three_wire && three_hold)
      begin
         next_run_fwd_latch = (run_fwd_latch || forward_run_cmd) &&
                              !reverse_run_cmd;
         next_run_rev_latch = (run_rev_latch || reverse_run_cmd) &&
                              !forward_run_cmd;
      end
      run_fwd = three_wire ? run_fwd_latch : forward_run_cmd;
      run_rev = three_wire ? run_rev_latch : reverse_run_cmd;
   end

   // Clamp helpers
   function automatic logic [15:0] clamp(input logic [15:0] v,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
      if (v > hi)
         return hi;
      else if (v < lo)
         return lo;
      return v;
   endfunction : clamp

   // Up-down reference
   logic [15:0] ud_ref;
   logic [15:0] next_ud_ref;
   logic [15:0] next_saved;
   logic [15:0] edge_saved;
   logic [15:0] next_edge_saved;
   logic raise_d;
   logic lower_d;
   logic [31:0] hold_cnt;
   logic [31:0] next_hold_cnt;
   logic [31:0] tick_cnt;
   logic [31:0] next_tick_cnt;
   logic tick;
   logic step_busy;
   logic [15:0] step_goal;
   logic next_step_busy;
   logic [15:0] next_step_goal;
   logic cont;
   logic stop_edge;
   logic run_any;
   logic run_d;
   logic [15:0] hi_lim;
   logic [15:0] lo_lim;
   always_comb
   begin
      run_any = run_fwd || run_rev;
      stop_edge = run_d && !run_any;
      tick = (tick_cnt >= TICK_CYCLES - 1);
      next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
      hi_lim = (speed_cfg.high_limit < speed_cfg.max_speed_limit) ?
               speed_cfg.high_limit : speed_cfg.max_speed_limit;
      lo_lim = speed_cfg.low_limit;
      next_ud_ref = ud_ref;
      next_saved = updown_saved_reference;
      next_edge_saved = edge_saved;
      next_step_busy = step_busy;
      next_step_goal = step_goal;
      next_hold_cnt = (raise || lower) ? hold_cnt + 32'h1 : 32'h0;
      // held 3 s in mode 2 turns continuous
      cont = (updown_mode_select == tsc_pkg::UPDOWN_MODE_CONT) ||
             (updown_mode_select == tsc_pkg::UPDOWN_MODE_COMBO &&
              hold_cnt >= HOLD_CYCLES);
      if (hold_cnt >= HOLD_CYCLES)
         next_hold_cnt = hold_cnt;
      if (cont && updown_mode_select == tsc_pkg::UPDOWN_MODE_CONT)
         next_step_busy = 1'b0;
      if (cont && tick && raise && !lower)
         next_ud_ref = clamp(ud_ref + speed_cfg.ramp_rate, lo_lim, hi_lim);
      else if (cont && tick && lower && !raise)
         next_ud_ref = (ud_ref > lo_lim + speed_cfg.ramp_rate) ?
                       ud_ref - speed_cfg.ramp_rate : lo_lim;
      else if (step_busy && tick)
      begin
         // steps move at the ramp rate
         if (ud_ref + speed_cfg.ramp_rate < step_goal)
            next_ud_ref = ud_ref + speed_cfg.ramp_rate;
         else if (ud_ref > step_goal + speed_cfg.ramp_rate)
            next_ud_ref = ud_ref - speed_cfg.ramp_rate;
         else
         begin
            next_ud_ref = step_goal;
            next_step_busy = 1'b0;
         end
      end
      // one step per rising edge; ignored while busy
      if (!cont && !step_busy && raise && !raise_d)
      begin
         next_step_goal = clamp(ud_ref + speed_cfg.updown_step_size,
                                lo_lim, hi_lim);
         next_step_busy = 1'b1;
      end
      else if (!cont && !step_busy && lower && !lower_d)
      begin
         next_step_goal = (ud_ref > lo_lim + speed_cfg.updown_step_size) ?
                          ud_ref - speed_cfg.updown_step_size : lo_lim;
         next_step_busy = 1'b1;
      end
      if ((raise_d && !raise) || (lower_d && !lower))
         next_edge_saved = ud_ref;
      if (updown_save_enable)
      begin
         if (updown_mode_select == tsc_pkg::UPDOWN_MODE_STEP)
         begin
            // store the reference at each release
            if ((raise_d && !raise) || (lower_d && !lower))
               next_saved = ud_ref;
            // stop keeps the last falling-edge value
            else if (stop_edge && ud_assigned)
               next_saved = edge_saved;
         end
         else if (stop_edge || (lower_d && !lower))
            next_saved = ud_ref;
      end
      // clear ignored while raise or lower held
      if (clr && !raise && !lower)
      begin
         next_saved = 16'h0000;
         next_ud_ref = 16'h0000;
      end
   end

   // Start sequencing
   tsc_pkg::tsc_state_e state;
   tsc_pkg::tsc_state_e next_state;
   logic [31:0] seq_cnt;
   logic [31:0] next_seq_cnt;
   logic [15:0] ms_out;
   always_comb
   begin
      next_state = state;
      next_seq_cnt = seq_cnt;
      if (tick)
         next_seq_cnt = seq_cnt + 32'h1;
      ms_out = 16'h0000;
      case (state)
         tsc_pkg::ST_IDLE:
         begin
            next_seq_cnt = 32'h0;
            if (run_any || jog || jog_fwd || jog_rev)
               next_state = tsc_pkg::ST_DWELL;
            else if (dc_stop_cmd)
               next_state = tsc_pkg::ST_STOP_DC;
         end
         tsc_pkg::ST_DWELL:
         begin
            ms_out = brake_cfg.dwell_speed;
            if (seq_cnt >= {16'h0, brake_cfg.dwell_time})
            begin
               next_seq_cnt = 32'h0;
               next_state = tsc_pkg::ST_START_DC;
            end
         end
         tsc_pkg::ST_START_DC:
         begin
            // skip on zero level or duration; accelerate after
            if (brake_cfg.start_dc_level == 8'h00 ||
                seq_cnt >= {16'h0, brake_cfg.start_dc_duration})
               next_state = tsc_pkg::ST_RUN;
         end
         tsc_pkg::ST_RUN:
         begin
            if (!(run_any || jog || jog_fwd || jog_rev))
               next_state = tsc_pkg::ST_IDLE;
         end
         tsc_pkg::ST_STOP_DC:
         begin
            if (!dc_stop_cmd || run_any)
               next_state = tsc_pkg::ST_IDLE;
         end
         default: next_state = tsc_pkg::ST_IDLE;
      endcase
   end

   // Output selection
   logic [15:0] next_speed_target;
   logic [15:0] next_output_speed;
   logic next_reverse_dir;
   logic next_dc_inject;
   logic [7:0] next_dc_level;
   logic [15:0] jog_clamped;
   logic [7:0] lvl;
   always_comb
   begin
      // jog speed limited by start and maximum speed
      jog_clamped = clamp(speed_cfg.jog_speed, speed_cfg.min_start_speed,
                          speed_cfg.max_speed_limit);
      // level is a 0..200 percent value
      lvl = (brake_cfg.start_dc_level > tsc_pkg::START_DC_LEVEL_MAX) ?
            tsc_pkg::START_DC_LEVEL_MAX : brake_cfg.start_dc_level;
      // jog first, then up-down or keypad
      if (jog || jog_fwd || jog_rev)
         next_speed_target = jog_clamped;
      else if (updown_sel)
         next_speed_target = ud_ref;
      else
         next_speed_target = clamp(keypad_reference,
                                   speed_cfg.min_start_speed,
                                   speed_cfg.max_speed_limit);
      if (jog_rev)
         next_reverse_dir = 1'b1;
      else if (jog_fwd)
         next_reverse_dir = 1'b0;
      else if (run_rev)
         next_reverse_dir = 1'b1;
      else if (run_fwd)
         next_reverse_dir = 1'b0;
      else
         next_reverse_dir = reverse_dir;
      next_output_speed = 16'h0000;
      next_dc_inject = 1'b0;
      next_dc_level = 8'h00;
      case (state)
         tsc_pkg::ST_DWELL: next_output_speed = ms_out;
         tsc_pkg::ST_START_DC:
         begin
            next_dc_inject = (lvl != 8'h00) &&
                             (brake_cfg.start_dc_duration != 16'h0000);
            next_dc_level = lvl;
         end
         tsc_pkg::ST_RUN: next_output_speed = next_speed_target;
         tsc_pkg::ST_STOP_DC:
         begin
            // hold DC while terminal asserted at stop
            next_dc_inject = (lvl != 8'h00);
            next_dc_level = lvl;
         end
         default: next_output_speed = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         run_fwd_latch <= 1'b0;
         run_rev_latch <= 1'b0;
         ud_ref <= 16'h0000;
         updown_saved_reference <= 16'h0000;
         edge_saved <= 16'h0000;
         raise_d <= 1'b0;
         lower_d <= 1'b0;
         hold_cnt <= 32'h0;
         tick_cnt <= 32'h0;
         step_busy <= 1'b0;
         step_goal <= 16'h0000;
         run_d <= 1'b0;
         state <= tsc_pkg::ST_IDLE;
         seq_cnt <= 32'h0;
         speed_target <= 16'h0000;
         output_speed <= 16'h0000;
         reverse_dir <= 1'b0;
         dc_inject <= 1'b0;
         dc_level <= 8'h00;
         running <= 1'b0;
      end
      else
      begin
         run_fwd_latch <= next_run_fwd_latch;
         run_rev_latch <= next_run_rev_latch;
         ud_ref <= next_ud_ref;
         updown_saved_reference <= next_saved;
         edge_saved <= next_edge_saved;
         raise_d <= raise;
         lower_d <= lower;
         hold_cnt <= next_hold_cnt;
         tick_cnt <= next_tick_cnt;
         step_busy <= next_step_busy;
         step_goal <= next_step_goal;
         run_d <= run_any;
         state <= next_state;
         seq_cnt <= next_seq_cnt;
         speed_target <= next_speed_target;
         output_speed <= next_output_speed;
         reverse_dir <= next_reverse_dir;
         dc_inject <= next_dc_inject;
         dc_level <= next_dc_level;
         running <= (next_state == tsc_pkg::ST_RUN);
      end
   end
endmodule : tsc_core
`default_nettype wire

// *** tb/tsc_monitor.sv ***
// Checker on the ports of the speed command core
`timescale 1ns/1ps
`default_nettype none
module tsc_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Settings
   input wire tsc_pkg::tsc_speed_cfg_s speed_cfg,
   input wire tsc_pkg::tsc_brake_cfg_s brake_cfg,
   input wire logic updown_save_enable,
   // Drive outputs
   input wire logic [15:0] speed_target,
   input wire logic [15:0] output_speed,
   input wire logic dc_inject,
   input wire logic [7:0] dc_level,
   input wire logic running,
   input wire logic [15:0] updown_saved_reference
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   level_range_a: assert property (dc_level <= 8'hC8)
      else $error("dc level above range");
   level_follow_a: assert property (dc_inject
      |-> dc_level == $past(brake_cfg.start_dc_level))
      else $error("dc level differs from setting");
   start_skip_a: assert property (dc_inject
      |-> $past(brake_cfg.start_dc_level) != 8'h00)
      else $error("start injection not skipped");
   level_nonzero_a: assert property (dc_inject |-> dc_level != 8'h00)
      else $error("injection with zero level");
   speed_max_a: assert property (output_speed
      <= speed_cfg.max_speed_limit)
      else $error("output speed above maximum");
   target_max_a: assert property (speed_target
      <= speed_cfg.max_speed_limit)
      else $error("target above maximum");
   save_gate_a: assert property ($changed(updown_saved_reference)
      |-> $past(updown_save_enable))
      else $error("saved reference moved while save off");
   save_range_a: assert property (updown_saved_reference <= 16'h9C40)
      else $error("saved reference out of range");
endmodule : tsc_monitor
bind tsc_core tsc_monitor mon_u (.clk(clk), .nrst(nrst),
   .speed_cfg(speed_cfg), .brake_cfg(brake_cfg),
   .updown_save_enable(updown_save_enable), .speed_target(speed_target),
   .output_speed(output_speed), .dc_inject(dc_inject), .dc_level(dc_level),
   .running(running), .updown_saved_reference(updown_saved_reference));
`default_nettype wire

// *** tb/tsc_switch_model.sv ***
// Switches on the input terminals, each held a minimum time
`timescale 1ns/1ps
`default_nettype none
module tsc_switch_model #(
   parameter int unsigned MIN_HOLD = 12
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Wanted and actual levels
   input wire logic [7:0] want,
   output var logic [7:0] input_terminal
);
   int unsigned age [8];
   always @(posedge clk or negedge nrst)
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (!nrst)
         begin
            input_terminal[i] <= 1'b0;
            age[i] <= 0;
         end
         else if (want[i] != input_terminal[i] && age[i] >= MIN_HOLD)
         begin
            input_terminal[i] <= want[i];
            age[i] <= 0;
         end
         else if (age[i] < MIN_HOLD)
            age[i] <= age[i] + 1;
      end
   end
endmodule : tsc_switch_model
`default_nettype wire

// *** tb/tsc_core_tb.sv ***
// Self-checking bench for the speed command core
`timescale 1ns/1ps
`default_nettype none
module tsc_core_tb;
   logic clk, nrst, fwd, rev, save_en, dci, rdir, run;
   logic [7:0] want, term, dcl;
   logic [39:0] fn;
   logic [3:0] fsrc;
   logic [1:0] mode;
   logic [15:0] kp, tgt, outs, saved, jog_e;
   tsc_pkg::tsc_speed_cfg_s scfg;
   tsc_pkg::tsc_brake_cfg_s bcfg;
   int fails, checked, cyc, seed, ref_m;
   int saved_q [$];
   tsc_switch_model sw_u (.clk(clk), .nrst(nrst), .want(want),
      .input_terminal(term));
   tsc_core #(.HOLD_CYCLES(200), .DEBOUNCE_CYCLES(4), .TICK_CYCLES(2)) dut_u (
      .clk(clk), .nrst(nrst), .input_terminal(term), .terminal_function(fn),
      .forward_run_cmd(fwd), .reverse_run_cmd(rev), .freq_source(fsrc),
      .keypad_reference(kp), .speed_cfg(scfg), .brake_cfg(bcfg),
      .updown_mode_select(mode), .updown_save_enable(save_en),
      .speed_target(tgt), .output_speed(outs), .reverse_dir(rdir),
      .dc_inject(dci), .dc_level(dcl), .running(run),
      .updown_saved_reference(saved));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [15:0] sig(input int w);
      case (w)
         0: return tgt;
         1: return outs;
         2: return saved;
         3: return {15'h0000, dci};
         4: return {8'h00, dcl};
         6: return {15'h0000, run};
         default: return {15'h0000, rdir};
      endcase
   endfunction : sig
   task automatic expect_sig(input int w, input logic [15:0] exp);
      int n;
      n = 0;
      @(negedge clk);
      while (sig(w) !== exp && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      checked++;
      if (sig(w) !== exp)
      begin
         fails++;
         $display("[ERR] %0t sig %0d got %h exp %h", $time, w, sig(w), exp);
      end
   endtask : expect_sig
   task automatic press(input int i);
      @(posedge clk) want[i] <= 1'b1;
      repeat (30) @(posedge clk);
      want[i] <= 1'b0;
      repeat (30) @(posedge clk);
   endtask : press
   task automatic set_fn(input int i, input logic [4:0] code);
      @(posedge clk) fn[5*i +: 5] <= code;
   endtask : set_fn
   task automatic finish_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 30000)
      begin
         fails++;
         finish_test();
      end
   end
   initial
   begin
      seed = 69;
      {nrst, fwd, rev, save_en, want, fn, fsrc, mode} = '0;
      kp = 16'(100 + ($unsigned($random(seed)) % 5000));
      scfg = '{16'h03E8, 16'h1770, 16'h0032, 16'h1388, 16'h0000, 16'h01F4,
         16'h2710};
      bcfg = '{8'h3C, 16'h0005, 16'h0000, 16'h0000};
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk) fwd <= 1'b1;
         if (k == 0)
         begin
            expect_sig(3, 16'h0001);
            expect_sig(4, 16'h003C);
         end
         expect_sig(1, kp);
         @(posedge clk) fwd <= 1'b0;
         expect_sig(1, 16'h0000);
         bcfg.start_dc_level <= 8'h00;
      end
      bcfg.start_dc_level <= 8'h3C;
      set_fn(2, tsc_pkg::FN_DC_BRAKE_STOP);
      @(posedge clk) want[2] <= 1'b1;
      expect_sig(3, 16'h0001);
      @(posedge clk) want[2] <= 1'b0;
      expect_sig(3, 16'h0000);
      set_fn(4, tsc_pkg::FN_JOG);
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk) scfg.jog_speed <= k ? 16'h2710
            : 16'(100 + ($unsigned($random(seed)) % 5000));
         fwd <= 1'b1;
         want[4] <= 1'b1;
         @(posedge clk) jog_e = scfg.jog_speed > 16'h1770 ? 16'h1770
            : scfg.jog_speed;
         expect_sig(1, jog_e);
         @(posedge clk) want[4] <= 1'b0;
         expect_sig(1, kp);
         @(posedge clk) fwd <= 1'b0;
         expect_sig(1, 16'h0000);
      end
      set_fn(5, tsc_pkg::FN_JOG_FWD);
      set_fn(6, tsc_pkg::FN_JOG_REV);
      for (int d = 0; d < 2; d++)
      begin
         @(posedge clk) want[6 - d] <= 1'b1;
         expect_sig(1, 16'h1770);
         expect_sig(5, 16'(1 - d));
         @(posedge clk) want[6 - d] <= 1'b0;
         expect_sig(1, 16'h0000);
      end
      set_fn(6, tsc_pkg::FN_RAISE);
      set_fn(7, tsc_pkg::FN_LOWER);
      set_fn(1, tsc_pkg::FN_SAVED_CLEAR);
      @(posedge clk) fsrc <= tsc_pkg::FREQ_SRC_UPDOWN;
      mode <= tsc_pkg::UPDOWN_MODE_CONT;
      save_en <= 1'b1;
      fwd <= 1'b1;
      @(posedge clk) want[6] <= 1'b1;
      expect_sig(0, 16'h1388);
      @(posedge clk) want[6] <= 1'b0;
      want[7] <= 1'b1;
      expect_sig(0, 16'h0000);
      @(posedge clk) want[7] <= 1'b0;
      mode <= tsc_pkg::UPDOWN_MODE_STEP;
      press(1);
      expect_sig(2, 16'h0000);
      ref_m = 0;
      saved_q.delete();
      for (int k = 0; k < 3; k++)
      begin
         press(k < 2 ? 6 : 7);
         ref_m += k < 2 ? 500 : -500;
         saved_q.push_back(ref_m);
         expect_sig(0, 16'(ref_m));
      end
      expect_sig(2, 16'(saved_q[$]));
      @(posedge clk) want[6] <= 1'b1;
      repeat (20) @(posedge clk);
      press(1);
      expect_sig(2, 16'(saved_q[$]));
      @(posedge clk) want[6] <= 1'b0;
      ref_m += 500;
      expect_sig(2, 16'(ref_m));
      press(1);
      expect_sig(2, 16'h0000);
      @(posedge clk) mode <= tsc_pkg::UPDOWN_MODE_COMBO;
      want[6] <= 1'b1;
      expect_sig(0, scfg.updown_step_size);
      repeat (100) @(posedge clk);
      expect_sig(0, scfg.updown_step_size);
      expect_sig(0, scfg.high_limit);
      @(posedge clk) want[6] <= 1'b0;
      fwd <= 1'b0;
      expect_sig(6, 16'h0000);
      set_fn(3, tsc_pkg::FN_THREE_WIRE);
      @(posedge clk) want[3] <= 1'b1;
      repeat (20) @(posedge clk);
      fwd <= 1'b1;
      @(posedge clk) fwd <= 1'b0;
      expect_sig(6, 16'h0001);
      repeat (40) @(posedge clk);
      expect_sig(6, 16'h0001);
      @(posedge clk) want[3] <= 1'b0;
      expect_sig(6, 16'h0000);
      finish_test();
   end
endmodule : tsc_core_tb
`default_nettype wire
